// *** hw/stq_map.vh ***
// Purpose: register offsets, fields, reset values and timing counts
// Assumes: 32-bit apb data, one aligned word per register
// Notes: included by the trigger qualifier files
`ifndef STQ_MAP_VH
`define STQ_MAP_VH

`define STQ_CTRL_ADDR 12'h000
`define STQ_COUNT_ADDR 12'h004
`define STQ_DUR_ADDR 12'h008
`define STQ_DMAX_ADDR 12'h00C
`define STQ_PAT_ADDR 12'h010
`define STQ_STAT_ADDR 12'h014
`define STQ_ARM_ADDR 12'h018

// ctrl fields
`define STQ_CTRL_MODE_LO 0
`define STQ_CTRL_MODE_HI 1
`define STQ_CTRL_SRC 2
`define STQ_CTRL_SLOPE 3
`define STQ_CTRL_AUTO 4
`define STQ_CTRL_WHEN_LO 5
`define STQ_CTRL_WHEN_HI 7
// src=0 ch1, slope=0 rising, auto on, when entered, mode edge
`define STQ_CTRL_RESET 8'h10

`define STQ_MODE_EDGE 2'd0
`define STQ_MODE_PAT 2'd1
`define STQ_MODE_IMM 2'd2

`define STQ_WHEN_ENTER 3'd0
`define STQ_WHEN_EXIT 3'd1
`define STQ_WHEN_GT 3'd2
`define STQ_WHEN_LT 3'd3
`define STQ_WHEN_RANGE 3'd4

`define STQ_COUNT_MIN 15'h0001
`define STQ_COUNT_MAX 15'h7D00
`define STQ_DUR_MIN 24'h00_0002
`define STQ_DUR_MAX 24'hF4_2400
`define STQ_DMIN_MAX 24'h00_0010
`define STQ_DUR_RESET 24'h00_0002
`define STQ_DMAX_RESET 24'h00_0003

// timing
`define STQ_CLK_NS 20
`define STQ_TICK_NS 10
`define STQ_TICKS_PER_CLK (`STQ_CLK_NS / `STQ_TICK_NS)
`define STQ_AUTO_MS 50
`define STQ_AUTO_CYCLES ((`STQ_AUTO_MS * 1000000) / `STQ_CLK_NS)

`endif

// *** hw/stq_sync.v ***
// Purpose: two flop synchroniser for one level per bit
// Assumes: destination clock is clk
// Notes: first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none

module stq_sync #(
  parameter WIDTH = 2
) (
  input wire clk,
  input wire reset,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;

endmodule // stq_sync

`default_nettype wire

// *** hw/stq_trigger.v ***
// Purpose: scope trigger qualifier with apb registers
// Assumes: comparator inputs are levels, one per channel
// Notes: one trigger strobe per arming, then idles until re-armed
// Operation
// - source selector picks channel one or two
// - source defaults to channel one
// - slope selects rising or falling, reset rising
// - edge trigger after programmed edge count
// - event count 1 to 32000, reset 1
// - auto trigger after 50 ms, flag set
// - auto off waits forever, waiting status
// - auto trigger enabled after reset
// - entered: fire when pattern becomes true
// - exited: fire when pattern turns false
// - pattern condition resets to entered
// - longer-than fires on long true interval
// - shorter-than fires on short true interval
// - range fires between minimum and maximum
// - single limit 20 ns to 160 ms
// - range minimum 20-160 ns, max above
// - only first counted event needs duration
// - channel term high, low or ignored
// - all ignored pattern never triggers
// - mode edge, pattern or immediate
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "stq_map.vh"

module stq_trigger #(
  parameter AUTO_CYCLES = `STQ_AUTO_CYCLES
) (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [1:0] comp_above,
  output reg trig_strobe,
  output reg auto_triggered,
  output reg waiting
);

  localparam ST_IDLE = 2'd0;
  localparam ST_SEARCH = 2'd1;
  localparam ST_DONE = 2'd2;

  reg [7:0] ctrl;
  reg [14:0] count_cfg;
  reg [23:0] dur_cfg;
  reg [23:0] dmax_cfg;
  reg [3:0] pat_cfg;
  reg [1:0] state;
  reg [14:0] ev_cnt;
  reg [23:0] dur_tmr;
  reg dur_met;
  reg [31:0] auto_cnt;
  reg prev_src;
  reg prev_pat;
  reg real_trig;
  reg arm_req;

  wire [1:0] comp_s;
  wire [1:0] mode = ctrl[`STQ_CTRL_MODE_HI:`STQ_CTRL_MODE_LO];
  wire [2:0] when_sel = ctrl[`STQ_CTRL_WHEN_HI:`STQ_CTRL_WHEN_LO];
  wire auto_en = ctrl[`STQ_CTRL_AUTO];
  wire wr_en = psel & penable & pwrite;
  wire [23:0] next_tmr;
  wire [23:0] wr_val = pwdata[23:0];
  wire src_lvl;
  wire edge_seen;
  wire pat_true;
  wire pat_rise;
  wire pat_fall;
  wire [1:0] term_ok;
  wire [1:0] term_used;
  wire dur_ok;

  stq_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in(comp_above),
    .sync_out(comp_s)
  );

  // single-cycle zero-wait apb slave; bad address flags an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr > `STQ_ARM_ADDR);

  assign src_lvl = comp_s[ctrl[`STQ_CTRL_SRC]];
  // rising when slope bit clear, falling when set
  assign edge_seen = ctrl[`STQ_CTRL_SLOPE] ? (prev_src & ~src_lvl)
                   : (~prev_src & src_lvl);

  // per channel: bit 2i = used, bit 2i+1 = want high
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_term
      assign term_used[c] = pat_cfg[2*c];
      assign term_ok[c] = ~pat_cfg[2*c] |
                          (comp_s[c] == pat_cfg[2*c+1]);
    end
  endgenerate

  assign pat_true = (|term_used) & (&term_ok);
  assign pat_rise = pat_true & ~prev_pat;
  assign pat_fall = ~pat_true & prev_pat;

  // timer in 10 ns units, saturating so long pulses stay long
  wire [31:0] tmr_sum = dur_tmr + `STQ_TICKS_PER_CLK;
  assign next_tmr = (dur_tmr > 24'hFF_FFFD) ? 24'hFF_FFFF
                  : tmr_sum[23:0];

  // range minimum is capped at 160 ns; the stored limit stays untouched
  // so a later switch back to the single-limit modes keeps its value
  wire [23:0] range_min = (dur_cfg > `STQ_DMIN_MAX) ? `STQ_DMIN_MAX
                        : dur_cfg;

  // dur_tmr holds the whole true time at the falling sample
  assign dur_ok = (when_sel == `STQ_WHEN_GT) ? (dur_tmr > dur_cfg)
    : (when_sel == `STQ_WHEN_LT) ? (dur_tmr < dur_cfg)
    : (dur_tmr > range_min) & (dur_tmr < dmax_cfg);

  // one event per pattern interval: entered counts rises, others falls
  reg pat_event;
  always @*
  begin
    pat_event = 1'b0;
    case (when_sel)
      `STQ_WHEN_ENTER: pat_event = pat_rise;
      `STQ_WHEN_EXIT: pat_event = pat_fall;
      `STQ_WHEN_GT,
      `STQ_WHEN_LT,
      `STQ_WHEN_RANGE: pat_event = pat_fall & (dur_met | dur_ok);
      default: pat_event = 1'b0;
    endcase
  end

  always @*
  begin
    real_trig = 1'b0;
    case (mode)
      `STQ_MODE_EDGE: real_trig = edge_seen & (ev_cnt + 15'd1 >= count_cfg);
      `STQ_MODE_PAT: real_trig = pat_event & (ev_cnt + 15'd1 >= count_cfg);
      `STQ_MODE_IMM: real_trig = 1'b1;
      default: real_trig = 1'b0;
    endcase
  end

  // register writes with range clamps
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl <= `STQ_CTRL_RESET;
      count_cfg <= `STQ_COUNT_MIN;
      dur_cfg <= `STQ_DUR_RESET;
      dmax_cfg <= `STQ_DMAX_RESET;
      pat_cfg <= 4'h0;
      arm_req <= 1'b0;
    end
    else
    begin
      arm_req <= wr_en & (paddr == `STQ_ARM_ADDR) & pwdata[0];
      if (wr_en)
      begin
        case (paddr)
          `STQ_CTRL_ADDR: ctrl <= pwdata[7:0];
          `STQ_COUNT_ADDR:
          begin
            if (pwdata[14:0] < `STQ_COUNT_MIN || pwdata[31:15] != 17'h0)
              count_cfg <= (pwdata[31:15] != 17'h0) ? `STQ_COUNT_MAX
                         : `STQ_COUNT_MIN;
            else if (pwdata[14:0] > `STQ_COUNT_MAX)
              count_cfg <= `STQ_COUNT_MAX;
            else
              count_cfg <= pwdata[14:0];
          end
          `STQ_DUR_ADDR:
          begin
            if (wr_val < `STQ_DUR_MIN)
              dur_cfg <= `STQ_DUR_MIN;
            else if (wr_val > `STQ_DUR_MAX)
              dur_cfg <= `STQ_DUR_MAX;
            else
              dur_cfg <= wr_val;
          end
          `STQ_DMAX_ADDR:
          begin
            if (wr_val <= dur_cfg)
              dmax_cfg <= dur_cfg + 24'h00_0001;
            else
              dmax_cfg <= wr_val;
          end
          `STQ_PAT_ADDR: pat_cfg <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  always @*
  begin
    case (paddr)
      `STQ_CTRL_ADDR: prdata = {24'h0, ctrl};
      `STQ_COUNT_ADDR: prdata = {17'h0, count_cfg};
      `STQ_DUR_ADDR: prdata = {8'h0, dur_cfg};
      `STQ_DMAX_ADDR: prdata = {8'h0, dmax_cfg};
      `STQ_PAT_ADDR: prdata = {28'h0, pat_cfg};
      `STQ_STAT_ADDR: prdata = {27'h0, state == ST_DONE, comp_s,
                                waiting, auto_triggered};
      default: prdata = 32'h0;
    endcase
  end

  // search engine
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      ev_cnt <= 15'h0;
      dur_tmr <= 24'h0;
      dur_met <= 1'b0;
      auto_cnt <= 32'h0;
      prev_src <= 1'b0;
      prev_pat <= 1'b0;
      trig_strobe <= 1'b0;
      auto_triggered <= 1'b0;
      waiting <= 1'b0;
    end
    else
    begin
      prev_src <= src_lvl;
      prev_pat <= pat_true;
      trig_strobe <= 1'b0;
      if (arm_req)
      begin
        state <= ST_SEARCH;
        ev_cnt <= 15'h0;
        dur_tmr <= 24'h0;
        dur_met <= 1'b0;
        auto_cnt <= 32'h0;
        auto_triggered <= 1'b0;
        waiting <= 1'b0;
      end
      else
      begin
        case (state)
          ST_SEARCH:
          begin
            dur_tmr <= pat_true ? next_tmr : 24'h0;
            if (real_trig)
            begin
              trig_strobe <= 1'b1;
              waiting <= 1'b0;
              state <= ST_DONE;
            end
            else if (auto_en && auto_cnt >= AUTO_CYCLES - 1)
            begin
              trig_strobe <= 1'b1;
              auto_triggered <= 1'b1;
              waiting <= 1'b0;
              state <= ST_DONE;
            end
            else
            begin
              auto_cnt <= auto_cnt + 32'h1;
              waiting <= ~auto_en;
              if (mode == `STQ_MODE_EDGE && edge_seen)
                ev_cnt <= ev_cnt + 15'h1;
              else if (mode == `STQ_MODE_PAT && pat_event)
              begin
                ev_cnt <= ev_cnt + 15'h1;
                dur_met <= 1'b1;
              end
            end
          end
          ST_DONE: state <= ST_DONE;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // stq_trigger

`default_nettype wire

// *** test/stq_comp_model.sv ***
// Purpose: level comparators of the two input channels
// Assumes: idle level below threshold on both channels
// Notes: pulses are driven by the bench through the pulse task
`timescale 1ns/1ns
`default_nettype none
module stq_comp_model (
  input wire logic clk,
  output logic [1:0] comp_above
);
  initial comp_above = 2'b00;
  // one pulse of w clocks; the low gap before a following pulse comes from that call's first clock wait
  task automatic pulse(input int ch, input int w);
    @(posedge clk);
    comp_above[ch] <= 1'b1;
    repeat (w) @(posedge clk);
    comp_above[ch] <= 1'b0;
  endtask
endmodule // stq_comp_model
`default_nettype wire

// *** test/stq_trigger_sva.sv ***
// Purpose: port checks for the trigger qualifier
// Assumes: zero-wait apb slave, one strobe per arming
// Notes: ctrl_q mirrors ctrl writes, reads are not needed
`timescale 1ns/1ns
`default_nettype none
`include "stq_map.vh"
module stq_trigger_sva #(
  parameter AUTO_CYCLES = 50
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] comp_above,
  input wire logic trig_strobe,
  input wire logic auto_triggered,
  input wire logic waiting
);
  logic [4:0] ctrl_q;
  always_ff @(posedge clk or posedge reset)
    if (reset)
      ctrl_q <= 5'h10;
    else if (psel && penable && pwrite && paddr == `STQ_CTRL_ADDR)
      ctrl_q <= pwdata[4:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_arm;
    psel && penable && pwrite && paddr == `STQ_ARM_ADDR && pwdata[0];
  endsequence
  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; psel && penable && paddr > 12'h018 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("pslverr missing");
  property p_ok; psel && penable && paddr <= 12'h018 |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("pslverr on mapped");
  property p_pulse; trig_strobe |=> !trig_strobe [*2]; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  property p_stat;
    psel && !pwrite && paddr == `STQ_STAT_ADDR
      |-> prdata[1:0] == {waiting, auto_triggered};
  endproperty
  a_stat: assert property (p_stat) else $error("status mismatch");
  property p_auto;
    $rose(auto_triggered)
      |-> (trig_strobe || $past(trig_strobe)) or (##1 trig_strobe);
  endproperty
  a_auto: assert property (p_auto) else $error("auto no strobe");
  property p_imm;
    s_arm ##0 (ctrl_q[1:0] == `STQ_MODE_IMM) |-> ##[1:4] trig_strobe;
  endproperty
  a_imm: assert property (p_imm) else $error("no immediate");
  property p_wait;
    s_arm ##0 (!ctrl_q[4] && ctrl_q[1:0] != `STQ_MODE_IMM) |-> ##[1:4] waiting;
  endproperty
  a_wait: assert property (p_wait) else $error("not waiting");
endmodule // stq_trigger_sva
bind stq_trigger stq_trigger_sva #(.AUTO_CYCLES(AUTO_CYCLES)) u_sva (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .comp_above(comp_above),
  .trig_strobe(trig_strobe), .auto_triggered(auto_triggered),
  .waiting(waiting));
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: directed bench for the trigger qualifier
// Assumes: auto timeout shortened to 50 cycles
// Notes: strobes are counted by a monitor, tests compare deltas
`timescale 1ns/1ns
`default_nettype none
`include "stq_map.vh"
module tb_top;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, trig_strobe, auto_triggered, waiting;
  wire [1:0] comp_above;
  int n_errors = 0, check_count = 0, hits = 0, cyc = 0, h0;
  always #10 clk = ~clk;
  stq_trigger #(.AUTO_CYCLES(50)) u_stq_trigger (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_above(comp_above), .trig_strobe(trig_strobe),
    .auto_triggered(auto_triggered), .waiting(waiting));
  stq_comp_model u_stq_comp_model (.clk(clk), .comp_above(comp_above));
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (trig_strobe === 1'b1)
      hits <= hits + 1;
    if (cyc == 6000)
    begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, e, rd);
  endtask
  task automatic arm(input logic [31:0] c);
    apb(1, `STQ_CTRL_ADDR, c);
    apb(1, `STQ_ARM_ADDR, 1);
    h0 = hits;
  endtask
  task automatic strobes(input int n, input int e);
    repeat (n) @(posedge clk);
    chk("strobes", e, hits - h0);
  endtask
  task automatic t_reset;
    rdc("ctrl", `STQ_CTRL_ADDR, 32'h0000_0010);
    rdc("count", `STQ_COUNT_ADDR, 32'h0000_0001);
    rdc("dur", `STQ_DUR_ADDR, 32'h0000_0002);
    rdc("pat", `STQ_PAT_ADDR, 32'h0000_0000);
    rdc("unmapped", 12'h01C, 32'h0000_0000);
    apb(1, `STQ_COUNT_ADDR, 32'h0000_7D01);
    rdc("count max", `STQ_COUNT_ADDR, 32'h0000_7D00);
    apb(1, `STQ_COUNT_ADDR, 32'h0000_0000);
    rdc("count min", `STQ_COUNT_ADDR, 32'h0000_0001);
    $display("t_reset done");
  endtask
  task automatic t_edge;
    arm(32'h0000_0002);
    strobes(8, 1);
    apb(1, `STQ_COUNT_ADDR, 3);
    arm(32'h0000_000C);
    u_stq_comp_model.pulse(1, 3);
    u_stq_comp_model.pulse(1, 3);
    u_stq_comp_model.pulse(0, 3);
    strobes(8, 0);
    chk("waiting", 1, waiting);
    rdc("stat wait", `STQ_STAT_ADDR, 32'h0000_0002);
    u_stq_comp_model.pulse(1, 3);
    strobes(8, 1);
    rdc("stat done", `STQ_STAT_ADDR, 32'h0000_0010);
    $display("t_edge done");
  endtask
  task automatic t_auto;
    arm(32'h0000_0010);
    strobes(70, 1);
    chk("auto flag", 1, auto_triggered);
    rdc("stat auto", `STQ_STAT_ADDR, 32'h0000_0011);
    arm(32'h0000_0000);
    strobes(3, 0);
    chk("auto clear", 0, auto_triggered);
    $display("t_auto done");
  endtask
  // long true interval of 200 ns: only the shorter-than mode must skip it
  task automatic t_pat;
    apb(1, `STQ_COUNT_ADDR, 1);
    apb(1, `STQ_PAT_ADDR, 32'h0000_0003);
    apb(1, `STQ_DUR_ADDR, 10);
    apb(1, `STQ_DMAX_ADDR, 5);
    rdc("dmax forced", `STQ_DMAX_ADDR, 32'h0000_000B);
    apb(1, `STQ_DMAX_ADDR, 32);
    rdc("dmax", `STQ_DMAX_ADDR, 32'h0000_0020);
    for (int w = 0; w < 5; w++)
    begin
      arm(32'(w << 5) | 32'h0000_0001);
      u_stq_comp_model.pulse(0, 10);
      strobes(8, (5'b10111 >> w) & 1);
    end
    // longer than 100 ns, count 3: 80 ns discarded, 200 ns is count 1
    apb(1, `STQ_COUNT_ADDR, 3);
    arm(32'h0000_0041);
    u_stq_comp_model.pulse(0, 4);
    u_stq_comp_model.pulse(0, 10);
    u_stq_comp_model.pulse(0, 3);
    strobes(8, 0);
    u_stq_comp_model.pulse(0, 3);
    strobes(8, 1);
    apb(1, `STQ_PAT_ADDR, 32'h0000_0000);
    arm(32'h0000_0001);
    u_stq_comp_model.pulse(0, 4);
    strobes(8, 0);
    $display("t_pat done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 0;
    t_reset;
    t_edge;
    t_auto;
    t_pat;
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
